// *** hdl/scip_issue_port.sv ***
// file: single command issue port, top level of the adapter side
// What this block does
// - level 000 disables, 001..111 pick level
// - drive vector byte on interrupt acknowledge
// - keep only final status block
// - ignore per-retry status request bit
// - entry bit zero at reset, toggles
// - status block written at bytes 36-51
`timescale 1ns/100ps
`default_nettype none
module scip_issue_port
(
	// clock and reset
	input wire logic clk,
	input wire logic resetn,
	// host port writes (same clock domain)
	input wire logic abp_wr,
	input wire logic [15:0] abp_data,
	input wire logic doorbell_wr,
	input wire logic [15:0] doorbell_data,
	// status port
	input wire logic adapter_running,
	output logic [1:0] status_port,
	// memory master
	output logic mem_req,
	output logic mem_we,
	output logic [31:0] mem_addr,
	output logic [7:0] mem_am,
	output logic [31:0] mem_wdata,
	input wire logic mem_ack,
	input wire logic [31:0] mem_rdata,
	// control field as loaded
	output logic [7:0] control_field,
	// command engine
	output logic cmd_start,
	output logic [31:0] cmd_word0,
	input wire logic cmd_retry_status_req,
	input wire logic sb_valid,
	input wire logic [1:0] sb_index,
	input wire logic [31:0] sb_word,
	input wire logic cmd_done,
	// interrupt
	output logic [2:0] irq_level,
	input wire logic iack,
	output logic [7:0] iack_data,
	output logic iack_valid
);
	import scip_pkg::*;

	scip_state_e state_q;
	logic [1:0] abp_cnt_q;
	logic [7:0] am_q;
	logic [31:0] base_q;
	logic [3:0] word_q;
	logic [15:0] intw_q;
	logic [31:0] sb_q [0:3];
	logic ent_q;
	logic ram_we;
	logic [31:0] ram_rd;
	logic go;
	logic pend_q;
	logic [7:0] run_am_q;
	logic [31:0] run_base_q;

	// only a zero written to the doorbell starts a command
	assign go = doorbell_wr && (doorbell_data == SCIP_DOORBELL_GO);

	// =========================================
	// address buffer port: control+am, address hi, address lo
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			abp_cnt_q <= 2'h0;
			control_field <= 8'h00;
			am_q <= 8'h00;
			base_q <= 32'h0000_0000;
		end
		else if (abp_wr)
		begin
			unique case (abp_cnt_q)
				2'h0:
				begin
					control_field <= abp_data[15:8];
					am_q <= abp_data[7:0];
				end
				2'h1: base_q[31:16] <= abp_data;
				default: base_q[15:0] <= abp_data;
			endcase
			// wrap after the low address word
			abp_cnt_q <= (abp_cnt_q == 2'h2) ? 2'h0 : abp_cnt_q + 2'h1;
		end
	end

	// =========================================
	// a doorbell rung while busy waits for idle
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			pend_q <= 1'b0;
			run_am_q <= 8'h00;
			run_base_q <= 32'h0000_0000;
		end
		else if (state_q != SCIP_IDLE)
		begin
			pend_q <= pend_q || go;
		end
		else
		begin
			pend_q <= 1'b0;
			run_am_q <= am_q;
			run_base_q <= base_q;
		end
	end

	// =========================================
	// sequencer
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			state_q <= SCIP_IDLE;
			word_q <= 4'h0;
		end
		else
		begin
			unique case (state_q)
				SCIP_IDLE:
				begin
					if (go || pend_q)
					begin
						state_q <= SCIP_FETCH;
						word_q <= SCIP_PB_FIRST_WORD;
					end
				end
				SCIP_FETCH:
				begin
					if (mem_ack)
					begin
						if (word_q == SCIP_INTW_WORD)
						begin
							state_q <= SCIP_EXEC;
						end
						word_q <= word_q + 4'h1;
					end
				end
				SCIP_EXEC:
				begin
					if (cmd_done)
					begin
						state_q <= SCIP_STORE;
						word_q <= SCIP_SB_FIRST_WORD;
					end
				end
				SCIP_STORE:
				begin
					if (mem_ack)
					begin
						if (word_q == SCIP_SB_LAST_WORD)
						begin
							// no interrupt when level is off
							state_q <= (intw_q[SCIP_INTW_LVL_HI:SCIP_INTW_LVL_LO]
								== SCIP_LVL_OFF) ? SCIP_IDLE : SCIP_IRQ;
						end
						word_q <= word_q + 4'h1;
					end
				end
				SCIP_IRQ:
				begin
					if (iack)
					begin
						state_q <= SCIP_ACK;
					end
				end
				SCIP_ACK: state_q <= SCIP_IDLE;
				default: state_q <= SCIP_IDLE;
			endcase
		end
	end

	// =========================================
	// memory master; frozen base/am let the host reload the port early
	assign mem_req = (state_q == SCIP_FETCH) || (state_q == SCIP_STORE);
	assign mem_we = (state_q == SCIP_STORE);
	assign mem_am = run_am_q;
	assign mem_addr = run_base_q + ({28'h0, word_q} << 2);
	assign mem_wdata = sb_q[word_q[1:0] - SCIP_SB_FIRST_WORD[1:0]];
	assign ram_we = (state_q == SCIP_FETCH) && mem_ack;

	scip_word_ram u_ram
	(
		.clk(clk),
		.wr_en(ram_we),
		.wr_addr(word_q),
		.wr_data(mem_rdata),
		.rd_addr(SCIP_PB_FIRST_WORD),
		.rd_data(ram_rd)
	);

	// =========================================
	// interrupt word capture, low half of word 7 in big-endian order
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			intw_q <= 16'h0000;
		end
		else if (ram_we && (word_q == SCIP_INTW_WORD))
		begin
			intw_q <= mem_rdata[15:0];
		end
	end

	// =========================================
	// command launch pulse as the fetch ends
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			cmd_start <= 1'b0;
			cmd_word0 <= 32'h0000_0000;
		end
		else
		begin
			cmd_start <= ram_we && (word_q == SCIP_INTW_WORD);
			cmd_word0 <= ram_rd;
		end
	end

	// =========================================
	// status block buffer: later blocks overwrite earlier ones, so
	// only the final one reaches memory; retry request is ignored
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			for (int i = 0; i < 4; i++)
			begin
				sb_q[i] <= 32'h0000_0000;
			end
		end
		else if (sb_valid && (state_q == SCIP_EXEC))
		begin
			sb_q[sb_index] <= sb_word;
		end
	end

	// =========================================
	// entry toggle: flips when a new command can be taken (prefetch
	// point is after the structure is copied in)
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			ent_q <= 1'b0;
		end
		else if (ram_we && (word_q == SCIP_INTW_WORD))
		begin
			ent_q <= ~ent_q;
		end
	end

	assign status_port = {adapter_running, ent_q};

	// =========================================
	// interrupt request and vector on acknowledge
	assign irq_level = (state_q == SCIP_IRQ) ?
		intw_q[SCIP_INTW_LVL_HI:SCIP_INTW_LVL_LO] : SCIP_LVL_OFF;

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			iack_data <= 8'h00;
			iack_valid <= 1'b0;
		end
		else
		begin
			iack_valid <= (state_q == SCIP_IRQ) && iack;
			iack_data <= intw_q[SCIP_INTW_VEC_HI:SCIP_INTW_VEC_LO];
		end
	end
endmodule : scip_issue_port
`default_nettype wire

// *** hdl/scip_word_ram.sv ***
// file: small memory holding a fetched copy of the structure words
`timescale 1ns/100ps
`default_nettype none
module scip_word_ram
(
	// clock
	input wire logic clk,
	// write side
	input wire logic wr_en,
	input wire logic [3:0] wr_addr,
	input wire logic [31:0] wr_data,
	// read side
	input wire logic [3:0] rd_addr,
	output logic [31:0] rd_data
);
	import scip_pkg::*;

	logic [31:0] mem [0:SCIP_STRUCT_WORDS-1];

	// =========================================
	// storage, read data registered
	always_ff @(posedge clk)
	begin
		if (wr_en)
		begin
			mem[wr_addr] <= wr_data;
		end
		rd_data <= mem[rd_addr];
	end
endmodule : scip_word_ram
`default_nettype wire

// *** include/scip_pkg.sv ***
// package: constants and types for the single command issue port
package scip_pkg;
	// structure layout, word indices within the 52-byte structure
	localparam int SCIP_STRUCT_BYTES = 52;
	localparam int SCIP_STRUCT_WORDS = 13;
	localparam logic [3:0] SCIP_PB_FIRST_WORD = 4'h0;
	localparam logic [3:0] SCIP_PB_LAST_WORD = 4'h7;
	localparam logic [3:0] SCIP_INTW_WORD = 4'h7;
	localparam logic [3:0] SCIP_SB_FIRST_WORD = 4'h9;
	localparam logic [3:0] SCIP_SB_LAST_WORD = 4'hC;
	localparam logic [3:0] SCIP_SB_WORDS = 4'h4;
	// interrupt word fields
	localparam int SCIP_INTW_LVL_HI = 10;
	localparam int SCIP_INTW_LVL_LO = 8;
	localparam int SCIP_INTW_VEC_HI = 7;
	localparam int SCIP_INTW_VEC_LO = 0;
	localparam logic [2:0] SCIP_LVL_OFF = 3'h0;
	// address buffer port load sequence length
	localparam logic [1:0] SCIP_ABP_LAST = 2'h3;
	// status port bits
	localparam int SCIP_STAT_ENT = 0;
	localparam int SCIP_STAT_RUN = 1;
	localparam logic [1:0] SCIP_STAT_RESET = 2'h0;
	// doorbell value that starts a command
	localparam logic [15:0] SCIP_DOORBELL_GO = 16'h0000;
	// address step between structure words
	localparam logic [31:0] SCIP_WORD_STEP = 32'h0000_0004;

	typedef enum logic [5:0] {
		SCIP_IDLE = 6'b000001,
		SCIP_FETCH = 6'b000010,
		SCIP_EXEC = 6'b000100,
		SCIP_STORE = 6'b001000,
		SCIP_IRQ = 6'b010000,
		SCIP_ACK = 6'b100000
	} scip_state_e;
endpackage : scip_pkg

// *** sim/scip_issue_port_asserts.sv ***
// checker: port-level properties of the single command issue port
`timescale 1ns/100ps
`default_nettype none
module scip_chk
(
	// clock and reset
	input wire logic clk,
	input wire logic resetn,
	// status
	input wire logic adapter_running,
	input wire logic [1:0] status_port,
	// memory master
	input wire logic mem_req,
	input wire logic mem_we,
	input wire logic [31:0] mem_addr,
	input wire logic mem_ack,
	// engine and interrupt
	input wire logic cmd_start,
	input wire logic [2:0] irq_level,
	input wire logic iack,
	input wire logic iack_valid
);
	import scip_pkg::*;
	// ========================================
	// properties
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
	sequence s_ack;
		mem_req && mem_ack;
	endsequence
	sequence s_more;
		mem_req && mem_we == $past(mem_we);
	endsequence
	property p_run;
		status_port[1] == adapter_running;
	endproperty
	a_run: assert property (p_run) else $error("running bit wrong");
	property p_ent;
		!(mem_req && mem_ack) |=> $stable(status_port[0]);
	endproperty
	a_ent: assert property (p_ent) else $error("entry bit moved");
	property p_start;
		$changed(status_port[0]) |-> ##[0:1] cmd_start;
	endproperty
	a_start: assert property (p_start) else $error("no start");
	property p_req;
		mem_req && !mem_ack |=> mem_req && $stable(mem_addr);
	endproperty
	a_req: assert property (p_req) else $error("request dropped");
	property p_step;
		s_ack ##1 s_more |-> mem_addr == $past(mem_addr) + 32'h4;
	endproperty
	a_step: assert property (p_step) else $error("bad step");
	property p_iack;
		iack && irq_level != SCIP_LVL_OFF |=> iack_valid;
	endproperty
	a_iack: assert property (p_iack) else $error("no vector");
	property p_irq;
		irq_level != SCIP_LVL_OFF && !iack |=> $stable(irq_level);
	endproperty
	a_irq: assert property (p_irq) else $error("level moved");
	property p_drop;
		iack_valid |-> irq_level == SCIP_LVL_OFF;
	endproperty
	a_drop: assert property (p_drop) else $error("irq kept");
endmodule : scip_chk
bind scip_issue_port scip_chk chk (.clk, .resetn, .adapter_running,
	.status_port, .mem_req, .mem_we, .mem_addr, .mem_ack, .cmd_start,
	.irq_level, .iack, .iack_valid);
`default_nettype wire

// *** sim/scip_mem_model.sv ***
// model: host memory holding the command structure
`timescale 1ns/100ps
`default_nettype none
module scip_mem_model
(
	// clock
	input wire logic clk,
	// memory slave
	input wire logic mem_req,
	input wire logic mem_we,
	input wire logic [31:0] mem_addr,
	input wire logic [31:0] mem_wdata,
	output logic mem_ack,
	output logic [31:0] mem_rdata
);
	// ========================================
	// storage and answer
	logic [31:0] w [0:31];
	logic slow_q = 1'b0;
	initial mem_ack = 1'b0;
	initial mem_rdata = 32'h0;
	// answers on alternate cycles so prompt and late acks both occur
	always @(posedge clk)
	begin
		slow_q <= ~slow_q;
		mem_ack <= 1'b0;
		mem_rdata <= ~mem_rdata; // idle bus shows stale data only on alternate cycles
		if (mem_req && !mem_ack && slow_q)
		begin
			mem_ack <= 1'b1;
			if (mem_we)
				w[mem_addr[6:2]] <= mem_wdata;
			else
				mem_rdata <= w[mem_addr[6:2]];
		end
	end
endmodule : scip_mem_model
`default_nettype wire

// *** sim/tb.sv ***
// testbench: issue port against the host memory model
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin \
	err_total++; $display("[FAIL] %s exp %h got %h", n, e, s); end end
module tb;
	import scip_pkg::*;
	// ========================================
	// signals
	logic clk = 1'b0, resetn = 1'b0, abp_wr = 1'b0, doorbell_wr = 1'b0;
	logic adapter_running = 1'b0, cmd_retry_status_req = 1'b0;
	logic sb_valid = 1'b0, cmd_done = 1'b0, iack = 1'b0;
	logic [15:0] abp_data = 16'h0, doorbell_data = 16'h0;
	logic [1:0] sb_index = 2'h0, status_port;
	logic [31:0] sb_word = 32'h0, mem_addr, mem_wdata, mem_rdata, cmd_word0;
	logic mem_req, mem_we, mem_ack, cmd_start, iack_valid;
	logic [7:0] mem_am, control_field, iack_data;
	logic [2:0] irq_level;
	int err_total = 0, compares = 0;
	scip_issue_port dut (.clk, .resetn, .abp_wr, .abp_data, .doorbell_wr,
		.doorbell_data, .adapter_running, .status_port, .mem_req, .mem_we,
		.mem_addr, .mem_am, .mem_wdata, .mem_ack, .mem_rdata,
		.control_field, .cmd_start, .cmd_word0, .cmd_retry_status_req,
		.sb_valid, .sb_index, .sb_word, .cmd_done, .irq_level, .iack,
		.iack_data, .iack_valid);
	scip_mem_model mem (.clk, .mem_req, .mem_we, .mem_addr, .mem_wdata,
		.mem_ack, .mem_rdata);
	// free-running clock
	initial forever #4 clk = ~clk;
	task automatic tick(int n);
		repeat (n) @(negedge clk);
	endtask : tick
	task automatic end_sim;
		$display("compares %0d mismatches %0d", compares, err_total);
		if (err_total == 0 && compares > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : end_sim
	task automatic give_up;
		err_total++;
		end_sim;
	endtask : give_up
	// one-cycle port writes; a spare cycle keeps strobes apart
	task automatic abp(logic [15:0] d);
		abp_data = d;
		abp_wr = 1'b1;
		tick(1);
		abp_wr = 1'b0;
		tick(1);
	endtask : abp
	task automatic ring(logic [15:0] d);
		doorbell_data = d;
		doorbell_wr = 1'b1;
		tick(1);
		doorbell_wr = 1'b0;
		tick(1);
	endtask : ring
	task automatic test_reset;
		`CHK("status", 2'h0, status_port)
		adapter_running = 1'b1;
		tick(1);
		`CHK("running", 1'b1, status_port[1])
		$display("test_reset done");
	endtask : test_reset
	// one command: build, load, ring, feed status blocks, check results
	task automatic run_cmd(logic [2:0] l, logic [7:0] v);
		int i;
		logic e;
		for (i = 0; i < 16; i++)
			mem.w[i] = 32'h0;
		for (i = 0; i < 7; i++)
			mem.w[i] = 32'hC0DE_0000 + i + l;
		mem.w[7] = {16'h0, 5'h0, l, v};
		abp(16'h843D);
		abp(16'h0000);
		abp(16'h0100);
		`CHK("ctrl", 8'h84, control_field)
		e = status_port[0];
		ring(16'h0001);
		`CHK("refused", 1'b0, mem_req)
		ring(SCIP_DOORBELL_GO);
		for (i = 0; i < 300 && cmd_start !== 1'b1; i++)
			tick(1);
		if (i == 300)
			give_up;
		`CHK("ent", ~e, status_port[0])
		`CHK("word0", 32'hC0DE_0000 + l, cmd_word0)
		`CHK("am", 8'h3D, mem_am)
		cmd_retry_status_req = 1'b1;
		sb_valid = 1'b1;
		for (i = 0; i < 8; i++)
		begin
			sb_index = i[1:0];
			sb_word = 32'h5B00_0000 + i;
			tick(1);
		end
		sb_valid = 1'b0;
		cmd_done = 1'b1;
		tick(1);
		cmd_done = 1'b0;
		for (i = 0; i < 300 && mem.w[12] !== 32'h5B00_0007; i++)
			tick(1);
		if (i == 300)
			give_up;
		tick(3);
		for (i = 0; i < 4; i++)
			`CHK("sb", 32'h5B00_0004 + i, mem.w[9 + i])
		`CHK("irq", l, irq_level)
		if (l != 3'h0)
		begin
			iack = 1'b1;
			tick(1);
			iack = 1'b0;
			`CHK("vector", v, iack_data)
			`CHK("iack", 1'b1, iack_valid)
		end
		tick(2);
	endtask : run_cmd
	task automatic test_levels;
		int l;
		for (l = 0; l < 8; l++)
			run_cmd(l[2:0], 8'hA0 + l[7:0]);
		$display("test_levels done");
	endtask : test_levels
	// second command rung while the first runs: it must wait, then use
	// its own address without moving the first one's status block
	task automatic test_prefetch;
		int i;
		for (i = 0; i < 32; i++)
			mem.w[i] = 32'h0;
		mem.w[0] = 32'hC0DE_00AA;
		mem.w[16] = 32'hC0DE_00BB;
		abp(16'h843D);
		abp(16'h0000);
		abp(16'h0100);
		ring(SCIP_DOORBELL_GO);
		for (i = 0; i < 300 && cmd_start !== 1'b1; i++)
			tick(1);
		if (i == 300)
			give_up;
		abp(16'h843D);
		abp(16'h0000);
		abp(16'h0140);
		ring(SCIP_DOORBELL_GO);
		`CHK("held", 1'b0, mem_req)
		sb_valid = 1'b1;
		for (i = 0; i < 4; i++)
		begin
			sb_index = i[1:0];
			sb_word = 32'h5B00_00A0 + i;
			tick(1);
		end
		sb_valid = 1'b0;
		cmd_done = 1'b1;
		tick(1);
		cmd_done = 1'b0;
		for (i = 0; i < 300 && cmd_start !== 1'b1; i++)
			tick(1);
		if (i == 300)
			give_up;
		`CHK("first sb", 32'h5B00_00A3, mem.w[12])
		`CHK("second w0", 32'hC0DE_00BB, cmd_word0)
		$display("test_prefetch done");
	endtask : test_prefetch
	// main sequence
	initial
	begin
		tick(10);
		test_reset;
		tick(9);
		resetn = 1'b1;
		`CHK("ent0", 1'b0, status_port[0])
		test_levels;
		test_prefetch;
		end_sim;
	end
endmodule : tb
`default_nettype wire
